// File: hw/dcp_defines.vh
// Purpose: shared constants for the deep colour pixel packer
// Assumes: included by bare name from every design file that needs it
// Notes: definitions only

`ifndef DCP_DEFINES_VH
`define DCP_DEFINES_VH

// ------------------------------------------------------------------
// clock, pixel word layout and pixel buffer size
// ------------------------------------------------------------------
`define DCP_MCLK_MHZ 125
`define DCP_COMP_W 16
`define DCP_PIX_W 19
`define DCP_PIX_DE 18
`define DCP_PIX_HS 17
`define DCP_PIX_VS 16
`define DCP_FIFO_DEPTH 8
`define DCP_FIFO_AW 3

// ------------------------------------------------------------------
// internal depth selections
// ------------------------------------------------------------------
`define DCP_SEL_24 2'h0
`define DCP_SEL_30 2'h1
`define DCP_SEL_36 2'h2
`define DCP_SEL_48 2'h3

// ------------------------------------------------------------------
// last phase of a group (fragments per group minus one)
// ------------------------------------------------------------------
`define DCP_LAST_24 3'h0
`define DCP_LAST_30 3'h4
`define DCP_LAST_36 3'h2
`define DCP_LAST_48 3'h1

// ------------------------------------------------------------------
// colour depth code values
// ------------------------------------------------------------------
`define DCP_CD_NONE 4'h0
`define DCP_CD_24 4'h4
`define DCP_CD_30 4'h5
`define DCP_CD_36 4'h6
`define DCP_CD_48 4'h7

// ------------------------------------------------------------------
// packing phase code values
// ------------------------------------------------------------------
`define DCP_PP_PH4 4'h0
`define DCP_PP_PH1 4'h1
`define DCP_PP_PH2 4'h2
`define DCP_PP_PH3 4'h3

`endif

// File: hw/dcp_fifo.v
// Purpose: pixel buffer in front of the packer
// Assumes: one clock, asynchronous active low reset
// Notes: in_ready and out_valid come from flops

`timescale 1ns/1ns

`include "dcp_defines.vh"

module dcp_fifo #(
	parameter WIDTH = 19,
	parameter DEPTH = 8,
	parameter AW = 3
) (
	input wire mclk, // core clock
	input wire resetn, // async reset, active low
	input wire [WIDTH-1:0] in_data, // word to store
	input wire in_valid, // word offered
	output reg in_ready, // room for a word
	output wire [WIDTH-1:0] out_data, // oldest word
	output reg out_valid, // a word is held
	input wire out_ready // oldest word taken
);

reg [WIDTH-1:0] mem [0:DEPTH-1];
reg [AW-1:0] wr_ptr_reg;
reg [AW-1:0] rd_ptr_reg;
reg [AW:0] count_reg;
reg [AW:0] count_next;
wire push;
wire pop;

assign push = in_valid & in_ready;
assign pop = out_ready & out_valid;
assign out_data = mem[rd_ptr_reg];

always @* begin
	count_next = count_reg;
	if (push & ~pop)
		count_next = count_reg + {{AW{1'b0}}, 1'b1};
	else if (pop & ~push)
		count_next = count_reg - {{AW{1'b0}}, 1'b1};
end

always @(posedge mclk) begin
	if (push)
		mem[wr_ptr_reg] <= in_data;
end

always @(posedge mclk or negedge resetn) begin
	if (!resetn) begin
		wr_ptr_reg <= {AW{1'b0}};
		rd_ptr_reg <= {AW{1'b0}};
		count_reg <= {(AW+1){1'b0}};
		in_ready <= 1'b0;
		out_valid <= 1'b0;
	end else begin
		if (push)
			wr_ptr_reg <= (wr_ptr_reg == DEPTH[AW-1:0] - {{(AW-1){1'b0}}, 1'b1}) ?
				{AW{1'b0}} : wr_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
		if (pop)
			rd_ptr_reg <= (rd_ptr_reg == DEPTH[AW-1:0] - {{(AW-1){1'b0}}, 1'b1}) ?
				{AW{1'b0}} : rd_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
		count_reg <= count_next;
		in_ready <= (count_next != DEPTH[AW:0]);
		out_valid <= (count_next != {(AW+1){1'b0}});
	end
end

endmodule // dcp_fifo

// File: hw/dcp_packer.v
// What this block does
// - pixels drawn at 1, 1.25, 1.5 or 2 characters per pixel by depth
// - groups are 1/1, 4/5, 2/3, 1/2 pixels per fragments
// - deep modes pack pixels and syncs in equal groups, one fragment per character
// - other link elements keep 24-bit character timing, packer frozen meanwhile
// - 24-bit sends one whole component per character, phase zero only
// - 30-bit five phases split four ten-bit pixels LSB first
// - 36-bit three phases split two twelve-bit pixels LSB first
// - 48-bit phase0 low byte, phase1 high byte
// - blanking carries one sync per pixel, last fragment repeats previous
// - 30-bit blanking sends S T U V V
// - 36-bit sends S T T, 48-bit S S, 24-bit S
// - 30-bit mid-group end of active video uses bridge steps then blanking
// - earliest pixel sync first, later ones in time order
// - link control packet request with phase at least once per field
// - sync and active-flag transitions keep fixed ratio to pixel clock
// - colour depth codes 0000, 0100, 0101, 0110, 0111
// - phase codes 0000 phase4, 0001 phase1, 0010 phase2, 0011 phase3
//
// Purpose: deep colour packer, one 8-bit fragment per link character
// Assumes: link_clk is sampled by mclk, at least four mclk per character
// Notes: pixels enter through an 8-word buffer with valid/ready

`timescale 1ns/1ns

`include "dcp_defines.vh"

module dcp_packer (
	input wire mclk, // core clock, 125 MHz
	input wire resetn, // async reset, active low
	input wire [15:0] pix_comp, // pixel component
	input wire pix_hsync, // horizontal sync of this pixel
	input wire pix_vsync, // vertical sync of this pixel
	input wire pix_active, // active_video_flag of this pixel
	input wire pix_valid, // pixel offered
	output wire pix_ready, // buffer takes the pixel
	input wire link_clk, // link character clock, from pin
	input wire [3:0] depth_code, // requested color_depth_code, from pin
	input wire other_elem, // preamble, guard band or island on the link
	output reg [7:0] frag_data_reg, // fragment to encoder bits 0-7
	output reg frag_hsync_reg, // sync value for this character
	output reg frag_vsync_reg, // sync value for this character
	output reg frag_active_reg, // fragment carries pixel bits
	output reg frag_other_reg, // character left to other link elements
	output reg [2:0] frag_phase_reg, // packing phase of the fragment
	output reg frag_valid_reg, // one-cycle pulse per character
	output reg [3:0] color_depth_code_reg, // depth now packed
	output reg [3:0] packing_phase_code_reg, // last active fragment phase
	output reg ctrl_pkt_req_reg, // pulse: send link_control_packet
	output reg underrun_reg // sticky: pixel wanted, buffer empty
);

// ------------------------------------------------------------------
// helper functions
// ------------------------------------------------------------------
function [2:0] last_phase;
	input [1:0] sel;
	begin
		case (sel)
			`DCP_SEL_30: last_phase = `DCP_LAST_30;
			`DCP_SEL_36: last_phase = `DCP_LAST_36;
			`DCP_SEL_48: last_phase = `DCP_LAST_48;
			default: last_phase = `DCP_LAST_24;
		endcase
	end
endfunction

// a new source pixel begins in this phase
function need_pix;
	input [1:0] sel;
	input [2:0] ph;
	begin
		case (sel)
			`DCP_SEL_30: need_pix = (ph < 3'h4);
			`DCP_SEL_36: need_pix = (ph < 3'h2);
			`DCP_SEL_48: need_pix = (ph == 3'h0);
			default: need_pix = 1'b1;
		endcase
	end
endfunction

function [7:0] frag_mux;
	input [1:0] sel;
	input [2:0] ph;
	input [15:0] c;
	input [15:0] n;
	begin
		frag_mux = n[7:0];
		case (sel)
			`DCP_SEL_30: begin
				case (ph)
					3'h1: frag_mux = {n[5:0], c[9:8]};
					3'h2: frag_mux = {n[3:0], c[9:6]};
					3'h3: frag_mux = {n[1:0], c[9:4]};
					3'h4: frag_mux = c[9:2];
					default: frag_mux = n[7:0];
				endcase
			end
			`DCP_SEL_36: begin
				case (ph)
					3'h1: frag_mux = {n[3:0], c[11:8]};
					3'h2: frag_mux = c[11:4];
					default: frag_mux = n[7:0];
				endcase
			end
			`DCP_SEL_48: begin
				if (ph == 3'h1)
					frag_mux = c[15:8];
				else
					frag_mux = n[7:0];
			end
			default: begin
				frag_mux = n[7:0];
			end
		endcase
	end
endfunction

// depth code decode, reserved codes fall back to 24 bits
function [1:0] code_to_sel;
	input [3:0] cd;
	begin
		case (cd)
			`DCP_CD_30: code_to_sel = `DCP_SEL_30;
			`DCP_CD_36: code_to_sel = `DCP_SEL_36;
			`DCP_CD_48: code_to_sel = `DCP_SEL_48;
			default: code_to_sel = `DCP_SEL_24;
		endcase
	end
endfunction

function [3:0] sel_to_code;
	input [1:0] sel;
	begin
		case (sel)
			`DCP_SEL_30: sel_to_code = `DCP_CD_30;
			`DCP_SEL_36: sel_to_code = `DCP_CD_36;
			`DCP_SEL_48: sel_to_code = `DCP_CD_48;
			default: sel_to_code = `DCP_CD_24;
		endcase
	end
endfunction

function [3:0] phase_to_code;
	input [2:0] ph;
	begin
		case (ph)
			3'h1: phase_to_code = `DCP_PP_PH1;
			3'h2: phase_to_code = `DCP_PP_PH2;
			3'h3: phase_to_code = `DCP_PP_PH3;
			default: phase_to_code = `DCP_PP_PH4;
		endcase
	end
endfunction

// ------------------------------------------------------------------
// pixel buffer
// ------------------------------------------------------------------
wire [`DCP_PIX_W-1:0] buf_data;
wire buf_valid;
wire buf_take;

dcp_fifo #(
	.WIDTH(`DCP_PIX_W),
	.DEPTH(`DCP_FIFO_DEPTH),
	.AW(`DCP_FIFO_AW)
) u_fifo (
	.mclk(mclk),
	.resetn(resetn),
	.in_data({pix_active, pix_hsync, pix_vsync, pix_comp}),
	.in_valid(pix_valid),
	.in_ready(pix_ready),
	.out_data(buf_data),
	.out_valid(buf_valid),
	.out_ready(buf_take)
);

// ------------------------------------------------------------------
// pin synchronisers
// ------------------------------------------------------------------
reg link_s1_reg;
reg link_s2_reg;
reg link_s3_reg;
reg [3:0] depth_s1_reg;
reg [3:0] depth_s2_reg;
wire link_rise;

always @(posedge mclk or negedge resetn) begin
	if (!resetn) begin
		link_s1_reg <= 1'b0;
		link_s2_reg <= 1'b0;
		link_s3_reg <= 1'b0;
		depth_s1_reg <= `DCP_CD_NONE;
		depth_s2_reg <= `DCP_CD_NONE;
	end else begin
		link_s1_reg <= link_clk;
		link_s2_reg <= link_s1_reg;
		link_s3_reg <= link_s2_reg;
		depth_s1_reg <= depth_code;
		depth_s2_reg <= depth_s1_reg;
	end
end

assign link_rise = link_s2_reg & ~link_s3_reg;

// ------------------------------------------------------------------
// group sequencing
// ------------------------------------------------------------------
reg [1:0] sel_reg;
reg [2:0] phase_reg;
reg bridge_reg;
reg last_vs_reg;
reg [`DCP_PIX_W-1:0] cur_reg;
reg [3:0] pp_last_reg;

wire slot;
wire need;
wire at_last;
wire [`DCP_PIX_W-1:0] np;
wire [`DCP_PIX_W-1:0] sync_src;
wire act;
wire bridge_next;

// other elements take the character, group state stays put
assign slot = link_rise & ~other_elem;
assign need = need_pix(sel_reg, phase_reg);
assign at_last = (phase_reg == last_phase(sel_reg));
// pixel draw rate follows the group ratio
assign buf_take = slot & need & buf_valid;
// an empty buffer repeats the held pixel rather than stall the link
assign np = buf_valid ? buf_data : cur_reg;
// active only where a fragment begins with a fresh active pixel or finishes one
assign act = (need & (phase_reg == 3'h0)) ? np[`DCP_PIX_DE] : cur_reg[`DCP_PIX_DE];
// bridge when the flag falls inside a 30-bit group
assign bridge_next = bridge_reg | ((sel_reg == `DCP_SEL_30) & need &
	(phase_reg != 3'h0) & cur_reg[`DCP_PIX_DE] & ~np[`DCP_PIX_DE]);
// sync from the pixel now in the slot, held pixel on spare slots and bridge steps
assign sync_src = (bridge_reg | ~need) ? cur_reg : np;

always @(posedge mclk or negedge resetn) begin
	if (!resetn) begin
		sel_reg <= `DCP_SEL_24;
		phase_reg <= 3'h0;
		bridge_reg <= 1'b0;
		cur_reg <= {`DCP_PIX_W{1'b0}};
		last_vs_reg <= 1'b0;
		pp_last_reg <= `DCP_PP_PH4;
	end else if (slot) begin
		if (need)
			cur_reg <= np;
		if (act)
			pp_last_reg <= phase_to_code(phase_reg);
		if (need)
			last_vs_reg <= np[`DCP_PIX_VS];
		// wrap at the group size of the depth in use
		if (at_last) begin
			phase_reg <= 3'h0;
			bridge_reg <= 1'b0;
			// new depth adopted only on a group boundary
			sel_reg <= code_to_sel(depth_s2_reg);
		end else begin
			phase_reg <= phase_reg + 3'h1;
			bridge_reg <= bridge_next;
		end
	end else if (phase_reg == 3'h0) begin
		// idle on a group boundary
		// so the first fragment after reset already uses the requested depth
		sel_reg <= code_to_sel(depth_s2_reg);
	end
end

// ------------------------------------------------------------------
// fragment outputs
// ------------------------------------------------------------------
always @(posedge mclk or negedge resetn) begin
	if (!resetn) begin
		frag_data_reg <= 8'h00;
		frag_hsync_reg <= 1'b0;
		frag_vsync_reg <= 1'b0;
		frag_active_reg <= 1'b0;
		frag_other_reg <= 1'b0;
		frag_phase_reg <= 3'h0;
		frag_valid_reg <= 1'b0;
		color_depth_code_reg <= `DCP_CD_24;
		packing_phase_code_reg <= `DCP_PP_PH4;
		ctrl_pkt_req_reg <= 1'b0;
		underrun_reg <= 1'b0;
	end else begin
		frag_valid_reg <= link_rise;
		ctrl_pkt_req_reg <= 1'b0;
		if (link_rise & other_elem) begin
			frag_other_reg <= 1'b1;
			frag_active_reg <= 1'b0;
		end else if (slot) begin
			frag_other_reg <= 1'b0;
			frag_data_reg <= frag_mux(sel_reg, phase_reg, cur_reg[15:0], np[15:0]);
			frag_active_reg <= act;
			// one sync value per source pixel
			frag_hsync_reg <= sync_src[`DCP_PIX_HS];
			frag_vsync_reg <= sync_src[`DCP_PIX_VS];
			frag_phase_reg <= phase_reg;
			color_depth_code_reg <= sel_to_code(sel_reg);
			if (need & ~buf_valid)
				underrun_reg <= 1'b1;
			// report once per field at the rising vertical sync
			if (need & np[`DCP_PIX_VS] & ~last_vs_reg) begin
				ctrl_pkt_req_reg <= 1'b1;
				// phase of the last active fragment, zero at 24 bits
				packing_phase_code_reg <= (sel_reg == `DCP_SEL_24) ?
					`DCP_PP_PH4 : pp_last_reg;
			end
		end
	end
end

endmodule // dcp_packer

// File: tb/dcp_packer_chk.sv
// Purpose: port checks for the packer
// Assumes: one mclk domain
// Notes: bound from the bench top
`timescale 1ns/1ns
module dcp_packer_chk (
	input wire mclk, // core clock
	input wire resetn, // reset, active low
	input wire link_clk, // link pin
	input wire [7:0] frag_data_reg, // fragment
	input wire frag_active_reg, // pixel flag
	input wire frag_other_reg, // other flag
	input wire [2:0] frag_phase_reg, // phase
	input wire frag_valid_reg, // character pulse
	input wire [3:0] color_depth_code_reg, // depth code
	input wire [3:0] packing_phase_code_reg, // phase code
	input wire ctrl_pkt_req_reg // packet request
);
	// ------
	// helpers
	// ------
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!resetn);
	logic [2:0] last_ph;
	logic [2:0] prev_ph_reg;
	logic [2:0] prev_last_reg;
	logic seen_reg;
	always @* begin
		case (color_depth_code_reg)
			4'h5: last_ph = 3'h4;
			4'h6: last_ph = 3'h2;
			4'h7: last_ph = 3'h1;
			default: last_ph = 3'h0;
		endcase
	end
	// the first fragment after reset has no predecessor to step from
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			prev_ph_reg <= 3'h0;
			prev_last_reg <= 3'h0;
			seen_reg <= 1'b0;
		end else if (frag_valid_reg && !frag_other_reg) begin
			prev_ph_reg <= frag_phase_reg;
			// wrap point of the depth that packed the previous fragment
			prev_last_reg <= last_ph;
			seen_reg <= 1'b1;
		end
	end
	// ------
	// properties
	// ------
	sequence s_pin_rise;
		!link_clk ##1 link_clk;
	endsequence
	property p_char_latency;
		s_pin_rise |-> ##[2:5] frag_valid_reg;
	endproperty
	a_char_latency: assert property (p_char_latency) else $error("late fragment");
	property p_one_per_char;
		frag_valid_reg |=> !frag_valid_reg [*8];
	endproperty
	a_one_per_char: assert property (p_one_per_char) else $error("extra fragment");
	property p_phase_step;
		frag_valid_reg && !frag_other_reg && seen_reg |->
			frag_phase_reg == ((prev_ph_reg == prev_last_reg) ? 3'h0 : prev_ph_reg + 3'h1);
	endproperty
	a_phase_step: assert property (p_phase_step) else $error("bad phase step");
	property p_other_hold;
		frag_valid_reg && frag_other_reg |->
			!frag_active_reg && $stable(frag_phase_reg) && $stable(frag_data_reg);
	endproperty
	a_other_hold: assert property (p_other_hold) else $error("other char moved");
	property p_req_on_char;
		ctrl_pkt_req_reg |-> frag_valid_reg ##1 !ctrl_pkt_req_reg;
	endproperty
	a_req_on_char: assert property (p_req_on_char) else $error("stray request");
	property p_pp_hold;
		!ctrl_pkt_req_reg |-> $stable(packing_phase_code_reg);
	endproperty
	a_pp_hold: assert property (p_pp_hold) else $error("phase code moved");
	property p_pp_code;
		ctrl_pkt_req_reg |-> packing_phase_code_reg <= 4'h3 &&
			(color_depth_code_reg != 4'h4 || packing_phase_code_reg == 4'h0);
	endproperty
	a_pp_code: assert property (p_pp_code) else $error("bad phase code");
	property p_cd_legal;
		color_depth_code_reg >= 4'h4 && color_depth_code_reg <= 4'h7;
	endproperty
	a_cd_legal: assert property (p_cd_legal) else $error("bad depth code");
endmodule // dcp_packer_chk

// File: tb/dcp_sink_model.sv
// Purpose: sink unpacker facing the packer
// Assumes: fragments sampled on falling mclk
// Notes: keeps up to 8 pixels, 16 bits apart
`timescale 1ns/1ns
module dcp_sink_model (
	input wire mclk, // core clock
	input wire resetn, // reset, active low
	input wire frag_valid, // character pulse
	input wire frag_other, // other element
	input wire frag_active, // pixel bits
	input wire [2:0] frag_phase, // phase
	input wire [7:0] frag_data, // fragment
	input wire [3:0] cd_code, // depth code
	input wire pkt_req, // packet sent
	input wire [3:0] pp_code, // reported phase
	output logic [127:0] rx_pix, // pixels
	output logic [3:0] rx_n, // pixel count
	output logic phase_bad // report disagreed
);
	logic [31:0] acc;
	int nb;
	int w;
	logic [3:0] last_pp;
	always @* begin
		w = (cd_code == 4'h5) ? 10 : (cd_code == 4'h6) ? 12 : (cd_code == 4'h7) ? 16 : 8;
	end
	always @(negedge mclk or negedge resetn) begin
		if (!resetn) begin
			acc = 32'h0;
			nb = 0;
			rx_pix = 128'h0;
			rx_n = 4'h0;
			phase_bad = 1'b0;
			last_pp = 4'h0;
		end else if (frag_valid && !frag_other) begin
			if (pkt_req && pp_code !== last_pp)
				phase_bad = 1'b1;
			if (frag_active) begin
				if (frag_phase == 3'h0)
					nb = 0;
				acc = (nb == 0) ? {24'h0, frag_data} : acc | ({24'h0, frag_data} << nb);
				nb = nb + 8;
				last_pp = (frag_phase == 3'h4) ? 4'h0 : {1'b0, frag_phase};
				if (nb >= w) begin
					rx_pix[rx_n * 16 +: 16] = acc[15:0] & ((16'h1 << w) - 16'h1);
					acc = acc >> w;
					nb = nb - w;
					rx_n = rx_n + 4'h1;
				end
			end
		end
	end
endmodule // dcp_sink_model

// File: tb/tb.sv
// Purpose: self-checking bench for the packer
// Assumes: link pin made here, low between bursts
// Notes: 8 pixels are loaded while the link stalls
`timescale 1ns/1ns
`include "dcp_defines.vh"
module tb;
	logic mclk = 1'b0, resetn = 1'b0, link_clk = 1'b0, other_elem = 1'b0, pix_valid = 1'b0;
	logic pix_hsync = 1'b0, pix_vsync = 1'b0, pix_active = 1'b0;
	logic [15:0] pix_comp = 16'h0;
	logic [3:0] depth_code = 4'h4;
	wire [7:0] fd;
	wire fh, fv, fa, fo, fval, req, pix_ready, phase_bad, urun;
	wire [2:0] fp;
	wire [3:0] cd, pp, rx_n;
	wire [127:0] rx_pix;
	int fails = 0, n_compared = 0, nf = 0, n_oth = 0, n_req = 0, oth_at = 0;
	logic [7:0] q_d [64];
	logic [2:0] q_p [64];
	logic q_h [64], q_v [64], q_a [64];
	logic [15:0] px [8] = '{16'h1234, 16'hfedc, 16'h0a5f, 16'h8001, 16'h7ffe, 16'h3c96,
		16'hc3a5, 16'h5aa5};
	logic [7:0] hs = 8'hb2, vs = 8'h69;
	dcp_packer i_dut (.mclk(mclk), .resetn(resetn), .pix_comp(pix_comp), .pix_hsync(pix_hsync),
		.pix_vsync(pix_vsync), .pix_active(pix_active), .pix_valid(pix_valid),
		.pix_ready(pix_ready), .link_clk(link_clk), .depth_code(depth_code),
		.other_elem(other_elem), .frag_data_reg(fd), .frag_hsync_reg(fh), .frag_vsync_reg(fv),
		.frag_active_reg(fa), .frag_other_reg(fo), .frag_phase_reg(fp), .frag_valid_reg(fval),
		.color_depth_code_reg(cd), .packing_phase_code_reg(pp), .ctrl_pkt_req_reg(req),
		.underrun_reg(urun));
	dcp_sink_model i_sink (.mclk(mclk), .resetn(resetn), .frag_valid(fval), .frag_other(fo),
		.frag_active(fa), .frag_phase(fp), .frag_data(fd), .cd_code(cd), .pkt_req(req),
		.pp_code(pp), .rx_pix(rx_pix), .rx_n(rx_n), .phase_bad(phase_bad));
	initial forever #4 mclk = ~mclk;
	// ------
	// monitor and helpers
	// ------
	always @(negedge mclk) begin
		if (fval === 1'b1 && fo === 1'b1)
			n_oth <= n_oth + 1;
		else if (fval === 1'b1) begin
			q_d[nf] <= fd;
			q_p[nf] <= fp;
			q_h[nf] <= fh;
			q_v[nf] <= fv;
			q_a[nf] <= fa;
			nf <= nf + 1;
		end
		if (fval === 1'b1 && req === 1'b1)
			n_req <= n_req + 1;
		// other characters only start on a group boundary
		other_elem <= oth_at != 0 && nf == oth_at && n_oth < 8;
	end
	task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic final_report();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic start(input logic [3:0] code);
		@(negedge mclk);
		depth_code = code;
		resetn = 1'b0;
		nf = 0;
		n_oth = 0;
		n_req = 0;
		repeat (2) @(negedge mclk);
		resetn = 1'b1;
		repeat (2) @(negedge mclk);
	endtask
	task automatic load(input logic [7:0] a);
		for (int j = 0; j < 8; j++) begin
			pix_comp = px[j];
			pix_hsync = hs[j];
			pix_vsync = vs[j];
			pix_active = a[j];
			pix_valid = 1'b1;
			@(posedge mclk);
			while (pix_ready !== 1'b1)
				@(posedge mclk);
			@(negedge mclk);
		end
		pix_valid = 1'b0;
		repeat (2) @(negedge mclk);
		chk("ready when full", pix_ready, 1'b0);
	endtask
	task automatic run_link(input int n);
		repeat (n) begin
			#3 link_clk = 1'b1;
			#40 link_clk = 1'b0;
			#37;
		end
		repeat (12) @(negedge mclk);
	endtask
	// ------
	// scenarios
	// ------
	task automatic t_pack(input int d, input logic a);
		int w, l, p, o, m, idx;
		logic [127:0] s;
		w = (d == 0) ? 8 : (d == 1) ? 10 : (d == 2) ? 12 : 16;
		l = (d == 0) ? 1 : (d == 1) ? 5 : (d == 2) ? 3 : 2;
		p = l * 8 / w;
		m = (1 << w) - 1;
		o = (a && d == 1) ? 8 : 0;
		s = '0;
		for (int j = 0; j < 8; j++)
			s = s | ((128'(px[j]) & 128'(m)) << (w * j));
		start(4'h4 + d[3:0]);
		oth_at = o ? l : 0;
		load({8{a}});
		run_link(w + o);
		oth_at = 0;
		chk("depth code", cd, 4'h4 + d[3:0]);
		chk("fragment count", nf, w);
		chk("other count", n_oth, o);
		chk("ready drained", pix_ready, 1'b1);
		chk("no underrun", urun, 1'b0);
		for (int i = 0; i < w; i++) begin
			idx = (i / l) * p + ((i % l) < p ? i % l : p - 1);
			chk("phase", q_p[i], i % l);
			chk("active flag", q_a[i], a);
			if (a)
				chk("fragment", q_d[i], s[8 * i +: 8]);
			else
				chk("sync", {q_h[i], q_v[i]}, {hs[idx], vs[idx]});
		end
		for (int j = 0; j < 8 && a; j++)
			chk("unpacked pixel", rx_pix[16 * j +: 16], px[j] & m[15:0]);
		$display("pack test done depth %0d active %0b", d, a);
	endtask
	task automatic t_bridge();
		int idx;
		start(`DCP_CD_30);
		hs = 8'h0a;
		vs = 8'hf0;
		load(8'h01);
		run_link(10);
		for (int i = 2; i < 10; i++) begin
			idx = (i < 5) ? i - 1 : 4 + ((i < 9) ? i - 5 : 3);
			chk("bridge sync", q_h[i], hs[idx]);
			chk("bridge active", q_a[i], 1'b0);
		end
		chk("packet count", n_req, 1);
		chk("phase code", pp, `DCP_PP_PH1);
		chk("sink alignment", phase_bad, 1'b0);
		chk("no early underrun", urun, 1'b0);
		run_link(1);
		chk("underrun", urun, 1'b1);
		$display("bridge test done");
	endtask
	initial begin
		#100000;
		fails++;
		$display("watchdog expired");
		final_report();
	end
	initial begin
		start(4'h4);
		for (int d = 0; d < 4; d++) begin
			t_pack(d, 1'b1);
			t_pack(d, 1'b0);
		end
		t_bridge();
		final_report();
	end
endmodule // tb
bind dcp_packer dcp_packer_chk i_chk (.mclk, .resetn, .link_clk, .frag_data_reg, .frag_active_reg,
	.frag_other_reg, .frag_phase_reg, .frag_valid_reg, .color_depth_code_reg,
	.packing_phase_code_reg, .ctrl_pkt_req_reg);
